// ==== tpo_core.v ====
// Time-proportioning output stage with an AXI4-Lite register port.
// Overview of operation
// - Period setting 0..600 s, zero selects automatic.
// - Automatic mode adapts period to keep ripple constant.
// - Automatic period 4x min pulse at half demand.
// - Fixed nonzero period held while demand constant.
// - Fixed mode stretches period to honour min pulse.
// - Normal sense: output off when demand off.
// - Inverted sense: output off while alarm active.
// - Digital input active high normal, low inverted.
// - Valve outputs allow motor run-on, 0..30 s.
// - Valve outputs add linkage slack time, 0..30 s.
// - Standby action: hold, open or close valve.
// - Raise on lower channel, lower on next.
// - Bad input status selects substitute demand.
// - Min pulse between any switching, 0..150 s, 0=auto.
// - On fraction of period equals demand.
`timescale 1ns/1ps
`include "tpo_regs.vh"
module tpo_core #(
    parameter TICK_CYCLES = `TPO_TICK_CYCLES
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        alarm_active,
    input  wire        digital_in_pin,
    output reg         duty_switched_output,
    output reg         valve_raise,
    output reg         valve_lower,
    output reg         digital_in_active
);
    localparam S_CALC = 3'h0;
    localparam S_DIV1 = 3'h1;
    localparam S_DIV2 = 3'h2;
    localparam S_LOAD = 3'h3;
    localparam S_ON   = 3'h4;
    localparam S_OFF  = 3'h5;

    reg [5:0]  ctrl;
    reg [9:0]  demand;
    reg [9:0]  pulse_period_setting;
    reg [10:0] min_pulse;
    reg [8:0]  motor_run_on_time;
    reg [8:0]  linkage_slack_time;
    reg [9:0]  bad_status_substitute;

    reg [7:0]  aw_addr;
    reg        aw_held;
    reg [31:0] w_data;
    reg [3:0]  w_strb;
    reg        w_held;

    reg [2:0]  state;
    reg [23:0] div_num;
    reg [9:0]  div_den;
    reg [9:0]  div_rem;
    reg [4:0]  div_cnt;
    reg [23:0] short_len;
    reg [23:0] on_len;
    reg [23:0] off_len;
    reg [23:0] phase_cnt;
    reg        hi_side;
    reg        last_dir;
    reg        alarm_meta;
    reg        alarm_sync;
    reg        din_meta;
    reg        din_sync;

    wire        tick;
    wire        point_polarity = ctrl[`TPO_CTRL_POL];
    wire        vp_mode        = ctrl[`TPO_CTRL_VP];
    wire        standby        = ctrl[`TPO_CTRL_STANDBY_VALVE_ACTION];
    wire [1:0]  standby_valve_action = ctrl[`TPO_CTRL_ACT_HI:`TPO_CTRL_ACT_LO];
    wire [9:0]  eff_demand;
    wire [9:0]  dm;
    wire [10:0] min_eff;
    wire [23:0] min24;
    wire [23:0] period24;
    wire [10:0] rem_sh;
    wire        do_write;
    wire [31:0] wmerge;

    tpo_tick #(
        .CYCLES (TICK_CYCLES)
    ) u_tick (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (tick)
    );

    // Replaces the loop demand while the input status is bad.
    assign eff_demand = ctrl[`TPO_CTRL_BAD] ? bad_status_substitute : demand;
    // Distance from the nearer of fully off and fully on; the shorter interval follows it.
    assign dm = (eff_demand > `TPO_DEMAND_HALF) ? (`TPO_DEMAND_MAX - eff_demand) : eff_demand;
    assign min_eff  = (min_pulse == 11'h000) ? `TPO_MINP_AUTO : min_pulse;
    assign min24    = {13'h0000, min_eff};
    assign period24 = {14'h0000, pulse_period_setting} * 24'h00000A;
    assign rem_sh   = {div_rem, div_num[23]};

    // Register writes: address and data may arrive in either order.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            aw_held       <= 1'b0;
            w_held        <= 1'b0;
            aw_addr       <= 8'h00;
            w_data        <= 32'h0000_0000;
            w_strb        <= 4'h0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (do_write) begin
                w_held <= 1'b0;
            end
        end
    end

    assign do_write = aw_held && w_held && !s_axi_bvalid;

    function [31:0] merge;
        input [31:0] old;
        input [31:0] new_val;
        input [3:0]  strb;
        integer i;
        begin
            merge = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    merge[i*8 +: 8] = new_val[i*8 +: 8];
                end
            end
        end
    endfunction

    function [31:0] read_reg;
        input [7:0] addr;
        begin
            case (addr)
                `TPO_CTRL_ADDR:   read_reg = {26'h0, ctrl};
                `TPO_DEMAND_ADDR: read_reg = {22'h0, demand};
                `TPO_PERIOD_ADDR: read_reg = {22'h0, pulse_period_setting};
                `TPO_MINP_ADDR:   read_reg = {21'h0, min_pulse};
                `TPO_RUNON_ADDR:  read_reg = {23'h0, motor_run_on_time};
                `TPO_SLACK_ADDR:  read_reg = {23'h0, linkage_slack_time};
                `TPO_FALLBK_ADDR: read_reg = {22'h0, bad_status_substitute};
                `TPO_STATUS_ADDR: read_reg = {25'h0, state, digital_in_active,
                                              valve_lower, valve_raise,
                                              duty_switched_output};
                default:          read_reg = 32'h0000_0000;
            endcase
        end
    endfunction

    assign wmerge = merge(read_reg(aw_addr), w_data, w_strb);

    // Settings whose low 16 bits exceed their range are clipped so the timing never overflows.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl                  <= `TPO_CTRL_RST;
            demand                <= `TPO_DEMAND_RST;
            pulse_period_setting  <= `TPO_PERIOD_RST;
            min_pulse             <= `TPO_MINP_RST;
            motor_run_on_time     <= `TPO_RUNON_RST;
            linkage_slack_time    <= `TPO_SLACK_RST;
            bad_status_substitute <= `TPO_FALLBK_RST;
            s_axi_bvalid          <= 1'b0;
            s_axi_bresp           <= `TPO_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `TPO_RESP_OKAY;
            case (aw_addr)
                `TPO_CTRL_ADDR:   ctrl <= wmerge[5:0];
                `TPO_DEMAND_ADDR: demand <= (wmerge[15:0] > 16'h03E8) ?
                                            `TPO_DEMAND_MAX : wmerge[9:0];
                `TPO_PERIOD_ADDR: pulse_period_setting <= (wmerge[15:0] > 16'h0258) ?
                                            `TPO_PERIOD_MAX : wmerge[9:0];
                `TPO_MINP_ADDR:   min_pulse <= (wmerge[15:0] > 16'h05DC) ?
                                            `TPO_MINP_MAX : wmerge[10:0];
                `TPO_RUNON_ADDR:  motor_run_on_time <= (wmerge[15:0] > 16'h012C) ?
                                            `TPO_TIME30_MAX : wmerge[8:0];
                `TPO_SLACK_ADDR:  linkage_slack_time <= (wmerge[15:0] > 16'h012C) ?
                                            `TPO_TIME30_MAX : wmerge[8:0];
                `TPO_FALLBK_ADDR: bad_status_substitute <= (wmerge[15:0] > 16'h03E8) ?
                                            `TPO_DEMAND_MAX : wmerge[9:0];
                `TPO_STATUS_ADDR: s_axi_bresp <= `TPO_RESP_OKAY;
                default:          s_axi_bresp <= `TPO_RESP_SLVERR;
            endcase
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Register reads answer one cycle after the address is taken.
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `TPO_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= read_reg(s_axi_araddr);
                s_axi_rresp  <= (s_axi_araddr[7:2] > 6'h07 || s_axi_araddr[1:0] != 2'h0) ?
                                `TPO_RESP_SLVERR : `TPO_RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Pulse scheduler. Each period starts in S_CALC, which sets up the division; S_DIV1 works out the shorter of the on and
    // off intervals, then a subtraction (fixed period) or S_DIV2 (auto or stretched period) the longer one so the duty matches the demand.
    always @(posedge aclk) begin
        if (!aresetn) begin
            state     <= S_CALC;
            div_num   <= 24'h000000;
            div_den   <= 10'h000;
            div_rem   <= 10'h000;
            div_cnt   <= 5'h00;
            short_len <= 24'h000000;
            on_len    <= 24'h000000;
            off_len   <= 24'h000000;
            phase_cnt <= 24'h000000;
            hi_side   <= 1'b0;
            last_dir  <= 1'b0;
        end else begin
            case (state)
                S_CALC: begin
                    hi_side <= eff_demand > `TPO_DEMAND_HALF;
                    div_rem <= 10'h000;
                    div_cnt <= 5'h00;
                    div_den <= `TPO_DEMAND_MAX;
                    if (eff_demand == 10'h000 ||
                        (vp_mode && eff_demand == `TPO_DEMAND_HALF)) begin
                        on_len  <= 24'h000000;
                        off_len <= min24;
                        state   <= S_LOAD;
                    end else if (eff_demand == `TPO_DEMAND_MAX) begin
                        on_len  <= min24;
                        off_len <= 24'h000000;
                        state   <= S_LOAD;
                    end else begin
                        // Fixed: period share of dm; auto: twice the min pulse at half.
                        div_num <= ((pulse_period_setting != 10'h000) ? period24 :
                                    {min24[21:0], 2'b00}) * {14'h0000, dm};
                        state   <= S_DIV1;
                    end
                end
                S_DIV1, S_DIV2: begin
                    if (rem_sh >= {1'b0, div_den}) begin
                        div_rem <= rem_sh[9:0] - div_den;
                        div_num <= {div_num[22:0], 1'b1};
                    end else begin
                        div_rem <= rem_sh[9:0];
                        div_num <= {div_num[22:0], 1'b0};
                    end
                    div_cnt <= div_cnt + 5'h01;
                    if (div_cnt == 5'h17 && state == S_DIV1) begin
                        div_rem <= 10'h000;
                        div_cnt <= 5'h00;
                        div_den <= dm;
                        if (pulse_period_setting != 10'h000 &&
                            {div_num[22:0], rem_sh >= {1'b0, div_den}} >= min24) begin
                            short_len <= {div_num[22:0], rem_sh >= {1'b0, div_den}};
                            div_num   <= period24 - {div_num[22:0], rem_sh >= {1'b0, div_den}};
                            state     <= S_LOAD;
                        end else begin
                            // Auto period, or too short for the min pulse: stretch the period just enough.
                            short_len <= ({div_num[22:0], rem_sh >= {1'b0, div_den}} > min24) ?
                                         {div_num[22:0], rem_sh >= {1'b0, div_den}} : min24;
                            div_num   <= (({div_num[22:0], rem_sh >= {1'b0, div_den}} > min24) ?
                                         {div_num[22:0], rem_sh >= {1'b0, div_den}} : min24) *
                                         {14'h0000, `TPO_DEMAND_MAX - dm};
                            state     <= S_DIV2;
                        end
                    end else if (div_cnt == 5'h17) begin
                        state <= S_LOAD;
                    end
                end
                S_LOAD: begin
                    // Lengths come from the divider unless a constant level was chosen.
                    if (on_len != 24'h000000 || off_len != 24'h000000) begin
                        phase_cnt <= (on_len != 24'h000000) ? on_len : off_len;
                        state     <= (on_len != 24'h000000) ? S_ON : S_OFF;
                    end else begin
                        on_len    <= hi_side ? div_num : short_len;
                        off_len   <= hi_side ? short_len : div_num;
                        phase_cnt <= (hi_side ? div_num : short_len) +
                                     ((vp_mode && hi_side != last_dir) ?
                                      {15'h0000, linkage_slack_time} : 24'h000000);
                        last_dir  <= hi_side;
                        state     <= S_ON;
                    end
                end
                S_ON: begin
                    if (tick) begin
                        if (phase_cnt <= 24'h000001) begin
                            // The motor coasts after drive removal, so the rest is lengthened.
                            phase_cnt <= off_len + (vp_mode ?
                                         {15'h0000, motor_run_on_time} : 24'h000000);
                            state     <= (off_len == 24'h000000) ? S_CALC : S_OFF;
                            on_len    <= (off_len == 24'h000000) ? 24'h000000 : on_len;
                        end else begin
                            phase_cnt <= phase_cnt - 24'h000001;
                        end
                    end
                end
                S_OFF: begin
                    if (tick) begin
                        if (phase_cnt <= 24'h000001) begin
                            on_len  <= 24'h000000;
                            off_len <= 24'h000000;
                            state   <= S_CALC;
                        end else begin
                            phase_cnt <= phase_cnt - 24'h000001;
                        end
                    end
                end
                default: state <= S_CALC;
            endcase
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            alarm_meta <= 1'b0;
            alarm_sync <= 1'b0;
            din_meta   <= 1'b0;
            din_sync   <= 1'b0;
        end else begin
            alarm_meta <= alarm_active;
            alarm_sync <= alarm_meta;
            din_meta   <= digital_in_pin;
            din_sync   <= din_meta;
        end
    end

    // Outputs; in valve-mode standby the valve pair follows the configured action.
    always @(posedge aclk) begin
        if (!aresetn) begin
            duty_switched_output <= 1'b0;
            valve_raise          <= 1'b0;
            valve_lower          <= 1'b0;
            digital_in_active    <= 1'b0;
        end else begin
            digital_in_active <= point_polarity ? !din_sync : din_sync;
            if (vp_mode) begin
                duty_switched_output <= 1'b0;
                if (standby) begin
                    valve_raise <= standby_valve_action == `TPO_ACT_OPEN;
                    valve_lower <= standby_valve_action == `TPO_ACT_CLOSE;
                end else begin
                    valve_raise <= state == S_ON && hi_side;
                    valve_lower <= state == S_ON && !hi_side;
                end
            end else begin
                valve_raise          <= 1'b0;
                valve_lower          <= 1'b0;
                duty_switched_output <= point_polarity ? !alarm_sync :
                                        (!standby && state == S_ON);
            end
        end
    end
endmodule // tpo_core

// ==== tpo_regs.vh ====
// Register map, field positions, reset values and timing constants of the output stage.
`ifndef TPO_REGS_VH
`define TPO_REGS_VH

`define TPO_CTRL_ADDR     8'h00
`define TPO_DEMAND_ADDR   8'h04
`define TPO_PERIOD_ADDR   8'h08
`define TPO_MINP_ADDR     8'h0C
`define TPO_RUNON_ADDR    8'h10
`define TPO_SLACK_ADDR    8'h14
`define TPO_FALLBK_ADDR   8'h18
`define TPO_STATUS_ADDR   8'h1C

`define TPO_CTRL_POL      0
`define TPO_CTRL_BAD      1
`define TPO_CTRL_STANDBY_VALVE_ACTION     2
`define TPO_CTRL_VP       3
`define TPO_CTRL_ACT_LO   4
`define TPO_CTRL_ACT_HI   5

`define TPO_ACT_HOLD      2'h0
`define TPO_ACT_OPEN      2'h1
`define TPO_ACT_CLOSE     2'h2

`define TPO_CTRL_RST      6'h00
`define TPO_DEMAND_RST    10'h000
`define TPO_PERIOD_RST    10'h000
`define TPO_MINP_RST      11'h000
`define TPO_RUNON_RST     9'h000
`define TPO_SLACK_RST     9'h000
`define TPO_FALLBK_RST    10'h000

`define TPO_DEMAND_MAX    10'h3E8
`define TPO_DEMAND_HALF   10'h1F4
`define TPO_PERIOD_MAX    10'h258
`define TPO_MINP_MAX      11'h5DC
`define TPO_TIME30_MAX    9'h12C
`define TPO_MINP_AUTO     11'h00A

`define TPO_TICK_NS       100000000
`define TPO_CLK_NS        4
`define TPO_TICK_CYCLES   (`TPO_TICK_NS / `TPO_CLK_NS)

`define TPO_RESP_OKAY     2'h0
`define TPO_RESP_SLVERR   2'h2

`endif

// ==== tpo_tick.v ====
// Divider that makes the one-cycle tenth-of-a-second time base.
`timescale 1ns/1ps
module tpo_tick #(
    parameter CYCLES = 25000000
) (
    input  wire        aclk,
    input  wire        aresetn,
    output reg         tick
);
    reg [31:0] count;

    always @(posedge aclk) begin
        if (!aresetn) begin
            count <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (count >= CYCLES - 1) begin
            count <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule // tpo_tick

// ==== tpo_relay.sv ====
// Behavioural relay coil that times the on spans of its drive.
`timescale 1ns/1ps
module tpo_relay (
    input  wire        aclk,
    input  wire        coil,
    output reg  [31:0] on_len,
    output reg  [31:0] n_pulses
);
    reg        last;
    reg [31:0] span;
    initial begin
        last = 1'b0;
        span = 32'h0;
        on_len = 32'h0;
        n_pulses = 32'h0;
    end
    // A pulse is only counted when it ends, so a span cut by reconfiguration still counts.
    always @(posedge aclk) begin
        last <= coil;
        span <= (coil != last) ? 32'h1 : span + 32'h1;
        if (last && !coil) begin
            on_len <= span;
            n_pulses <= n_pulses + 32'h1;
        end
    end
endmodule // tpo_relay

// ==== tpo_checker.sv ====
// Port-level assertions for the output stage.
`timescale 1ns/1ps
`include "tpo_regs.vh"
module tpo_checker (
    input wire        aclk,
    input wire        aresetn,
    input wire [7:0]  s_axi_awaddr,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0]  s_axi_wstrb,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arready,
    input wire        s_axi_arvalid,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        alarm_active,
    input wire        digital_in_pin,
    input wire        duty_switched_output,
    input wire        valve_raise,
    input wire        valve_lower,
    input wire        digital_in_active
);
    reg  [7:0] wa;
    reg  [5:0] wd;
    reg        wl;
    reg        bq;
    reg  [5:0] ctl;
    reg  [3:0] since;
    wire       ok = since > 4'h4;
    // The shadow copy of the control word lags the real one, so checks wait a few cycles.
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctl <= 6'h00;
            since <= 4'h0;
            bq <= 1'b0;
        end else begin
            bq <= s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) wa <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) wd <= s_axi_wdata[5:0];
            if (s_axi_wvalid && s_axi_wready) wl <= s_axi_wstrb[0];
            if (s_axi_bvalid && !bq && s_axi_bresp == `TPO_RESP_OKAY
                && wa == `TPO_CTRL_ADDR && wl) begin
                ctl <= wd;
                since <= 4'h0;
            end else if (since != 4'hF) begin
                since <= since + 4'h1;
            end
        end
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    inv_alarm_a: assert property (ok && ctl[0] && !ctl[2] && !ctl[3] |->
        duty_switched_output == !$past(alarm_active, 3)) else $error("inverted output wrong");
    din_sense_a: assert property (ok |->
        digital_in_active == ($past(digital_in_pin, 3) ^ ctl[0])) else $error("input sense wrong");
    standby_valve_action_off_a: assert property (ok && !ctl[0] && ctl[2] && !ctl[3] |->
        !duty_switched_output) else $error("standby output not off");
    standby_valve_action_open_a: assert property (ok && ctl[3] && ctl[2] && ctl[5:4] == `TPO_ACT_OPEN |->
        valve_raise && !valve_lower) else $error("standby open wrong");
    standby_valve_action_close_a: assert property (ok && ctl[3] && ctl[2] && ctl[5:4] == `TPO_ACT_CLOSE |->
        valve_lower && !valve_raise) else $error("standby close wrong");
    standby_valve_action_hold_a: assert property (ok && ctl[3] && ctl[2] && ctl[5:4] == `TPO_ACT_HOLD |->
        !valve_raise && !valve_lower) else $error("standby hold wrong");
    pair_excl_a: assert property (!(valve_raise && valve_lower))
        else $error("raise and lower together");
    valve_only_a: assert property (ok && !ctl[3] |-> !valve_raise && !valve_lower)
        else $error("valve drive outside valve mode");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    cover property (ctl[3] && valve_raise);
    cover property (ctl[0] && duty_switched_output);
    cover property ($fell(duty_switched_output));
endmodule // tpo_checker

bind tpo_core tpo_checker u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arready, .s_axi_arvalid, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .alarm_active, .digital_in_pin, .duty_switched_output,
    .valve_raise, .valve_lower, .digital_in_active);

// ==== tb_top.sv ====
// Self-checking bench for the output stage.
`timescale 1ns/1ps
`include "tpo_regs.vh"
module tb_top;
    localparam int TC = 10;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, alarm, pin;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, on_len, n_pulses, d;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, r;
    logic awready, wready, bvalid, arready, rvalid, duty, raise, lower, din_act;
    int n_errors = 0;
    int num_checks = 0;
    tpo_core #(.TICK_CYCLES(TC)) dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .alarm_active(alarm),
        .digital_in_pin(pin), .duty_switched_output(duty), .valve_raise(raise),
        .valve_lower(lower), .digital_in_active(din_act));
    tpo_relay relay (.aclk(aclk), .coil(duty), .on_len(on_len), .n_pulses(n_pulses));
    always #2 aclk = ~aclk;
    task automatic chk(input [31:0] got, input [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        if (n_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic axw(input [7:0] a, input [31:0] v);
        int t = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            t++;
        end while (!bvalid && t < 50);
        bready <= 1'b0;
        chk(bresp, `TPO_RESP_OKAY);
        if (t >= 50) n_errors++;
    endtask
    task automatic axr(input [7:0] a);
        int t = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            t++;
        end while (!rvalid && t < 50);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (t >= 50) n_errors++;
    endtask
    task automatic t_reset;
        for (int i = 0; i < 7; i++) begin
            axr(8'(i * 4));
            chk(d, 32'h0);
        end
        axr(8'h20);
        chk(r, `TPO_RESP_SLVERR);
        chk(d, 32'h0);
    endtask
    task automatic clip(input [7:0] a, input [31:0] mx);
        axw(a, 32'hFFFF);
        axr(a);
        chk(d, mx);
    endtask
    task automatic t_sense;
        axw(`TPO_CTRL_ADDR, 32'h1);
        alarm <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(duty, 1'b0);
        alarm <= 1'b0;
        pin <= 1'b1;
        repeat (6) @(posedge aclk);
        chk(duty, 1'b1);
        chk(din_act, 1'b0);
        axw(`TPO_CTRL_ADDR, 32'h0);
        repeat (6) @(posedge aclk);
        chk(din_act, 1'b1);
        pin <= 1'b0;
    endtask
    // The third pulse is surely scheduled after both writes.
    task automatic meas(input [9:0] per, input [9:0] dem, input [31:0] tenths);
        int n0, t;
        axw(`TPO_PERIOD_ADDR, {22'h0, per});
        axw(`TPO_DEMAND_ADDR, {22'h0, dem});
        n0 = n_pulses;
        t = 0;
        while (n_pulses < n0 + 3 && t < 20000) begin
            @(posedge aclk);
            t++;
        end
        chk((on_len + TC - 1) / TC, tenths);
        if (t >= 20000) n_errors++;
    endtask
    task automatic t_valve;
        int cnt = 0;
        axw(`TPO_CTRL_ADDR, 32'h4);
        repeat (400) begin
            @(posedge aclk);
            cnt += duty;
        end
        chk(cnt, 0);
        for (int a = 0; a < 3; a++) begin
            axw(`TPO_CTRL_ADDR, {26'h0, 2'(a), 4'hC});
            repeat (6) @(posedge aclk);
            chk(raise, a == 1);
            chk(lower, a == 2);
        end
        axw(`TPO_CTRL_ADDR, 32'h8);
        repeat (4200) @(posedge aclk) cnt += raise ? 500 : lower;
        chk(cnt > 80 && cnt < 500, 1);
    endtask
    initial begin
        repeat (60000) @(posedge aclk);
        n_errors++;
        complete_run;
    end
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, alarm, pin} = 9'h000;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        clip(`TPO_PERIOD_ADDR, `TPO_PERIOD_MAX);
        clip(`TPO_MINP_ADDR, `TPO_MINP_MAX);
        clip(`TPO_RUNON_ADDR, `TPO_TIME30_MAX);
        clip(`TPO_SLACK_ADDR, `TPO_TIME30_MAX);
        t_sense;
        axw(`TPO_MINP_ADDR, 32'hA);
        meas(10'h0, 10'h1F4, 20);
        meas(10'h0, 10'h384, 90);
        meas(10'h4, 10'h2EE, 30);
        meas(10'h2, 10'h384, 90);
        axw(`TPO_FALLBK_ADDR, 32'h2EE);
        axw(`TPO_CTRL_ADDR, 32'h2);
        meas(10'h4, 10'h64, 30);
        t_valve;
        complete_run;
    end
endmodule // tb_top
